// *** inc/rcm_pkg.sv ***
// rcm_pkg: constants, register map and carrier types of the rtc control and clock
// output mask register bank.
// assumes: one clock domain (hclk), word-wide ahb-lite register access.

package rcm_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SECOND_CONTROL = 8'h10;
    localparam logic [7:0] IDX_GENERAL_BITS   = 8'h11;
    localparam logic [7:0] IDX_CLKOUT_MASK    = 8'h12;
    localparam logic [7:0] IDX_AUX_CONTROL    = 8'h20;
    localparam logic [7:0] IDX_STATUS         = 8'h21;
    localparam logic [7:0] IDX_PRESCALER      = 8'h22;

    // ------------------------------------------------------------
    // reset values and implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SECOND_CONTROL = 8'h00;
    localparam logic [7:0] RST_GENERAL_BITS   = 8'h00;
    localparam logic [7:0] RST_CLKOUT_MASK    = 8'h00;
    localparam logic [7:0] RST_AUX_CONTROL    = 8'h00;
    localparam logic [7:0] IMPL_GENERAL_BITS  = 8'h7F;
    localparam logic [7:0] IMPL_CLKOUT_MASK   = 8'h0F;
    localparam logic [7:0] IMPL_AUX_CONTROL   = 8'h07;

    // ------------------------------------------------------------
    // prescaler layout: stage 0 is 16384 hz, stage 14 is 1 hz
    // ------------------------------------------------------------
    localparam int unsigned PRE_STAGES    = 15;
    localparam int unsigned SYNC_LOW      = 2;   // first stage cleared by sync (4096 hz)
    localparam int unsigned CLOCK_OUTPUT_PIN_STAGE    = 1;   // 8192 hz square wave on clock output
    localparam int unsigned TIMER_STAGE   = 8;   // 64 hz countdown timer clock
    localparam int unsigned UPDATE_STAGE  = 14;  // 1 hz update timer clock
    localparam int unsigned STATUS_EVENT  = 0;   // write one clears the event flag

    // ahb transfer type bit that marks nonseq or seq
    localparam int unsigned HTRANS_ACTIVE = 1;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] other_bits;        // remaining control bits, stored only
        logic       event_irq_enable;  // bit 2
        logic       hour_12_mode;      // bit 1
        logic       sync_reset;        // bit 0, self clearing
    } rcm_ctrl_t;

    typedef struct packed {
        logic [3:0] unused;
        logic       clkout_on_event;   // bit 3
        logic       clkout_on_alarm;   // bit 2
        logic       clkout_on_countdown; // bit 1
        logic       clkout_on_update;  // bit 0
    } rcm_mask_t;

    typedef struct packed {
        logic [4:0] unused;
        logic       stamp_enable;      // bit 2
        logic       stamp_source_select; // bit 1
        logic       write_lock;        // bit 0
    } rcm_aux_t;

    typedef struct packed {
        logic alarm_irq_signal;
        logic countdown_irq_signal;
        logic update_irq_signal;
    } rcm_src_t;

endpackage : rcm_pkg

// *** rtl/rcm_prescaler.sv ***
// rcm_prescaler: fifteen-stage divider of the 32.768 khz oscillator tick.
// assumes: tick is a one-cycle pulse on hclk per oscillator period.

`timescale 1ns/100ps

module rcm_prescaler
    import rcm_pkg::*;
(
    input  wire logic                  hclk,         // bus clock
    input  wire logic                  hresetn,      // async reset, active low
    input  wire logic                  tick,         // oscillator edge pulse
    input  wire logic                  sync_clear,   // clear the upper stages
    output logic [PRE_STAGES-1:0]      stages_q,     // stage outputs, 16384 hz to 1 hz
    output logic                       second_carry_q // one-cycle pulse on 1 hz wrap
);

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    logic [PRE_STAGES-1:0] count_inc;
    logic [PRE_STAGES-1:0] count_sync;
    logic                  wrap;

    // plain increment and the variant that keeps only the bottom two stages
    assign count_inc  = stages_q + PRE_STAGES'(1);
    assign count_sync = {{(PRE_STAGES-SYNC_LOW){1'b0}},
                         (tick ? count_inc[SYNC_LOW-1:0] : stages_q[SYNC_LOW-1:0])};
    assign wrap       = tick & (&stages_q) & ~sync_clear;

    // ------------------------------------------------------------
    // stage register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stages_q       <= '0;
            second_carry_q <= 1'b0;
        end else begin
            second_carry_q <= wrap;
            if (sync_clear) begin
                stages_q <= count_sync;
            end else if (tick) begin
                stages_q <= count_inc;
            end
        end
    end

endmodule : rcm_prescaler

// *** rtl/rcm_regs.sv ***
// rcm_regs: rtc control register bank with clock output source mask.
// assumes: ahb-lite master on hclk, a single slave, word transfers only;
// osc_in and event_pin are asynchronous pins, all other inputs are on hclk.
//
// Our own choice: the AHB-Lite slave port.

`timescale 1ns/100ps

module rcm_regs
    import rcm_pkg::*;
(
    input  wire logic        hclk,                  // bus clock, 50 mhz
    input  wire logic        hresetn,               // async reset, active low
    input  wire logic        hsel,                  // slave select
    input  wire logic [31:0] haddr,                 // byte address
    input  wire logic [1:0]  htrans,                // transfer type
    input  wire logic        hwrite,                // write when high
    input  wire logic [2:0]  hsize,                 // transfer size, word expected
    input  wire logic [31:0] hwdata,                // write data
    input  wire logic        hready,                // bus ready
    output logic             hreadyout,             // slave ready
    output logic [31:0]      hrdata,                // read data
    output logic             hresp,                 // always okay
    input  wire logic        osc_in,                // 32.768 khz oscillator pin
    input  wire logic        event_pin,             // external event pin, rising edge
    input  wire logic        backup_switch,         // switchover pulse, hclk domain
    input  wire rcm_src_t    irq_src,               // alarm, countdown, update signals
    input  wire logic        second_update_taken,   // time counter consumed the update
    output logic             irq_pin_n,             // interrupt pin, active low
    output logic             clock_output_pin,      // gated clock output
    output logic             hour_12_mode,          // hour format for counters
    output logic             event_irq_signal,      // internal event interrupt
    output logic             second_update_pending, // memorized one-second update
    output logic             timer_clk,             // countdown timer clock
    output logic             update_clk             // update timer clock
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] osc_sync_q;
    logic       osc_prev_q;
    logic [1:0] event_sync_q;
    logic       event_prev_q;
    logic       osc_tick;
    logic       event_edge;

    // two flops per pin, then a history flop for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_sync_q   <= 2'h0;
            osc_prev_q   <= 1'b0;
            event_sync_q <= 2'h0;
            event_prev_q <= 1'b0;
        end else begin
            osc_sync_q   <= {osc_sync_q[0], osc_in};
            osc_prev_q   <= osc_sync_q[1];
            event_sync_q <= {event_sync_q[0], event_pin};
            event_prev_q <= event_sync_q[1];
        end
    end

    // rising edges of the synchronised pins
    assign osc_tick   = osc_sync_q[1] & ~osc_prev_q;
    assign event_edge = event_sync_q[1] & ~event_prev_q;

    // ------------------------------------------------------------
    // ahb-lite address and data phase
    // ------------------------------------------------------------
    logic       dph_valid_q;
    logic       dph_write_q;
    logic       dph_hit_q;
    logic [7:0] dph_idx_q;
    logic       addr_take;
    logic       addr_hit;

    // a transfer is taken when selected, ready and nonseq or seq
    assign addr_take = hsel & hready & htrans[HTRANS_ACTIVE];
    // full decode: upper bits zero and word aligned
    assign addr_hit  = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);

    // capture the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_valid_q <= 1'b0;
            dph_write_q <= 1'b0;
            dph_hit_q   <= 1'b0;
            dph_idx_q   <= 8'h00;
        end else begin
            dph_valid_q <= addr_take;
            dph_write_q <= addr_take & hwrite;
            if (addr_take) begin
                dph_hit_q <= addr_hit;
                dph_idx_q <= haddr[9:2];
            end
        end
    end

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    rcm_ctrl_t ctrl_q;
    logic [7:0] gp_q;
    rcm_mask_t mask_q;
    rcm_aux_t  aux_q;
    logic       wr_en;
    logic       wr_cfg;
    logic       wr_ctrl;
    logic       wr_gp;
    logic       wr_mask;
    logic       wr_aux;
    logic       wr_status;
    logic [7:0] wbyte;

    // writes commit in the data phase, which never waits
    assign wr_en     = dph_valid_q & dph_write_q & dph_hit_q;
    assign wr_cfg    = wr_en & ~aux_q.write_lock;
    assign wr_ctrl   = wr_cfg & (dph_idx_q == IDX_SECOND_CONTROL);
    assign wr_gp     = wr_cfg & (dph_idx_q == IDX_GENERAL_BITS);
    assign wr_mask   = wr_cfg & (dph_idx_q == IDX_CLKOUT_MASK);
    assign wr_aux    = wr_en & (dph_idx_q == IDX_AUX_CONTROL);
    assign wr_status = wr_en & (dph_idx_q == IDX_STATUS);
    assign wbyte     = hwdata[7:0];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------

    // second control: sync reset holds for one cycle, then clears itself
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= rcm_ctrl_t'(RST_SECOND_CONTROL);
        end else if (wr_ctrl) begin
            ctrl_q <= rcm_ctrl_t'(wbyte);
        end else if (ctrl_q.sync_reset) begin
            ctrl_q.sync_reset <= 1'b0;
        end
    end

    // general-purpose storage, bit 7 not implemented
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gp_q <= RST_GENERAL_BITS;
        end else if (wr_gp) begin
            gp_q <= wbyte & IMPL_GENERAL_BITS;
        end
    end

    // clock output source mask, upper nibble not implemented
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= rcm_mask_t'(RST_CLKOUT_MASK);
        end else if (wr_mask) begin
            mask_q <= rcm_mask_t'(wbyte & IMPL_CLKOUT_MASK);
        end
    end

    // write lock and stamp controls, never locked themselves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_q <= rcm_aux_t'(RST_AUX_CONTROL);
        end else if (wr_aux) begin
            aux_q <= rcm_aux_t'(wbyte & IMPL_AUX_CONTROL);
        end
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [PRE_STAGES-1:0] pre_stages;
    logic                  second_carry;

    // the sync bit drives the clear for exactly the cycle it is set
    rcm_prescaler u_prescaler (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .tick           (osc_tick),
        .sync_clear     (ctrl_q.sync_reset),
        .stages_q       (pre_stages),
        .second_carry_q (second_carry)
    );

    // ------------------------------------------------------------
    // event flag and interrupt pin
    // ------------------------------------------------------------
    logic event_flag_q;
    logic event_set;
    logic event_clr;

    // pin edge always sets, switchover only with stamp source and enable
    assign event_set = event_edge
                     | (backup_switch & aux_q.stamp_source_select & aux_q.stamp_enable);
    assign event_clr = wr_status & wbyte[STATUS_EVENT];

    // sticky flag; a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_flag_q <= 1'b0;
        end else begin
            event_flag_q <= event_set | (event_flag_q & ~event_clr);
        end
    end

    // ------------------------------------------------------------
    // memorized one-second update
    // ------------------------------------------------------------
    logic second_pending_q;

    // a sync reset discards the update; a new carry wins over taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            second_pending_q <= 1'b0;
        end else if (ctrl_q.sync_reset) begin
            second_pending_q <= 1'b0;
        end else begin
            second_pending_q <= second_carry | (second_pending_q & ~second_update_taken);
        end
    end

    // ------------------------------------------------------------
    // clock output gating
    // ------------------------------------------------------------
    logic [3:0] clk_sources;
    logic [3:0] clk_selected;
    logic       clkout_enable;

    // one source per mask bit, any selected one enables the output
    assign clk_sources   = {event_flag_q, irq_src.alarm_irq_signal,
                            irq_src.countdown_irq_signal, irq_src.update_irq_signal};
    assign clk_selected  = clk_sources & {mask_q.clkout_on_event,
                                          mask_q.clkout_on_alarm,
                                          mask_q.clkout_on_countdown,
                                          mask_q.clkout_on_update};
    assign clkout_enable = |clk_selected;

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic irq_pin_n_q;
    logic clock_output_pin_q;
    logic hour_12_mode_q;
    logic event_irq_signal_q;
    logic timer_clk_q;
    logic update_clk_q;

    // every pin and internal signal except the tied-off hresp leaves through a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_pin_n_q        <= 1'b1;
            clock_output_pin_q <= 1'b0;
            hour_12_mode_q     <= 1'b0;
            event_irq_signal_q <= 1'b0;
            timer_clk_q        <= 1'b0;
            update_clk_q       <= 1'b0;
        end else begin
            irq_pin_n_q        <= ~(ctrl_q.event_irq_enable & event_flag_q);
            clock_output_pin_q <= clkout_enable & pre_stages[CLOCK_OUTPUT_PIN_STAGE];
            hour_12_mode_q     <= ctrl_q.hour_12_mode;
            event_irq_signal_q <= event_flag_q;
            timer_clk_q        <= pre_stages[TIMER_STAGE];
            update_clk_q       <= pre_stages[UPDATE_STAGE];
        end
    end

    assign irq_pin_n             = irq_pin_n_q;
    assign clock_output_pin      = clock_output_pin_q;
    assign hour_12_mode          = hour_12_mode_q;
    assign event_irq_signal      = event_irq_signal_q;
    assign second_update_pending = second_pending_q;
    assign timer_clk             = timer_clk_q;
    assign update_clk            = update_clk_q;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0]  status_word;
    logic [31:0] rd_mux;
    logic        rd_cycle;
    logic        hreadyout_q;
    logic [31:0] hrdata_q;

    // live state: event flag, pin active, clock enabled, update pending
    assign status_word = {4'h0, second_pending_q, clkout_enable, ~irq_pin_n_q, event_flag_q};

    // reads never blocked by the lock; unmapped addresses read zero
    assign rd_mux = !dph_hit_q                          ? 32'h0000_0000 :
                    (dph_idx_q == IDX_SECOND_CONTROL)   ? {24'h0, ctrl_q} :
                    (dph_idx_q == IDX_GENERAL_BITS)     ? {24'h0, gp_q} :
                    (dph_idx_q == IDX_CLKOUT_MASK)      ? {24'h0, mask_q} :
                    (dph_idx_q == IDX_AUX_CONTROL)      ? {24'h0, aux_q} :
                    (dph_idx_q == IDX_STATUS)           ? {24'h0, status_word} :
                    (dph_idx_q == IDX_PRESCALER)        ? {17'h0, pre_stages} :
                                                          32'h0000_0000;

    // reads are sampled in the first data-phase cycle, which is the one wait cycle
    assign rd_cycle = dph_valid_q & ~dph_write_q;

    // a read address phase pulls ready low for exactly one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hrdata_q    <= 32'h0000_0000;
        end else begin
            hreadyout_q <= ~(addr_take & ~hwrite);
            if (rd_cycle) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata    = hrdata_q;
    assign hresp     = 1'b0;        // okay only

endmodule : rcm_regs

// *** sim/rcm_checker.sv ***
// rcm_checker: bus timing and output assertions for rcm_regs.
// assumes: bound onto rcm_regs, single hclk domain.
`timescale 1ns/100ps
module rcm_checker
    import rcm_pkg::*;
(
    input wire logic        hclk,             // bus clock
    input wire logic        hresetn,          // async reset, active low
    input wire logic        hsel,             // slave select
    input wire logic [1:0]  htrans,           // transfer type
    input wire logic        hwrite,           // write when high
    input wire logic        hready,           // bus ready
    input wire logic        hreadyout,        // slave ready
    input wire logic [31:0] hrdata,           // read data
    input wire logic        hresp,            // response
    input wire rcm_src_t    irq_src,          // interrupt sources
    input wire logic        irq_pin_n,        // interrupt pin
    input wire logic        clock_output_pin, // gated clock output
    input wire logic        event_irq_signal  // event interrupt
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // read accepted in this cycle
    wire rd_go = hsel & hready & htrans[1] & ~hwrite;
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait: assert property (rd_go |=> s_wait) else $error("read wait state wrong");
    a_ready_else: assert property (!rd_go |=> hreadyout) else $error("stray wait state");
    a_one_wait: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
    a_rdata_hold: assert property (!$past(rd_go, 2) |-> $stable(hrdata)) else $error("read data moved");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
    // event_irq_signal is the flag one cycle late, the same lag as the clock output flop
    a_clkout_src: assert property (clock_output_pin |-> ($past(irq_src) != 3'h0) || event_irq_signal)
        else $error("clock w/o source");
    a_irq_event: assert property (!irq_pin_n |-> event_irq_signal) else $error("irq without event");
endmodule : rcm_checker
bind rcm_regs rcm_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .irq_src(irq_src), .irq_pin_n(irq_pin_n), .clock_output_pin(clock_output_pin),
    .event_irq_signal(event_irq_signal));

// *** sim/rcm_far_model.sv ***
// rcm_far_model: oscillator and external event pin beside the bank.
// assumes: pins are asynchronous to hclk; crystal is scaled to 5 mhz.
`timescale 1ns/100ps
module rcm_far_model (
    output logic osc_in,   // oscillator pin
    output logic event_pin // external event pin
);
    // free running scaled crystal
    initial begin
        osc_in = 1'b0;
        event_pin = 1'b0;
    end
    always #100 osc_in = ~osc_in;
    // one rising edge on the event pin
    task automatic pulse_event();
        #3;
        event_pin = 1'b1;
        #400;
        event_pin = 1'b0;
    endtask : pulse_event
endmodule : rcm_far_model

// *** sim/rtc_control_and_clkout_mask_tb.sv ***
// rtc_control_and_clkout_mask_tb: self-checking bench of rcm_regs.
// assumes: one ahb master, the far model drives the async pins.
`timescale 1ns/100ps
module rtc_control_and_clkout_mask_tb;
    import rcm_pkg::*;
    logic hclk, hresetn, hwrite, hreadyout, hresp, osc_in, event_pin, bsw, irq_n, clko, h12, ev, pend, tclk, uclk;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    rcm_src_t    irq_src;
    int          fail_count, check_count;
    rcm_far_model i_far (.osc_in(osc_in), .event_pin(event_pin));
    rcm_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .osc_in(osc_in), .event_pin(event_pin), .backup_switch(bsw),
        .irq_src(irq_src), .second_update_taken(1'b0), .irq_pin_n(irq_n), .clock_output_pin(clko),
        .hour_12_mode(h12), .event_irq_signal(ev), .second_update_pending(pend), .timer_clk(tclk),
        .update_clk(uclk));
    function automatic logic [31:0] ba(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction : ba
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one ahb single transfer, waits on hready in both phases
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(r, exp);
    endtask : rd
    task automatic t_clkout(input logic [7:0] m, input logic [2:0] src, input logic exp);
        int hits;
        hits = 0;
        bus(1'b1, ba(IDX_CLKOUT_MASK), {24'h0, m});
        irq_src <= src;
        repeat (400) begin
            @(posedge hclk);
            if (clko === 1'b1) hits++;
        end
        check({31'h0, hits != 0}, {31'h0, exp});
        irq_src <= 3'h0;
        @(posedge hclk);
    endtask : t_clkout
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end
    // main sequence
    initial begin
        {hresetn, hwrite, bsw, htrans, haddr, hwdata, irq_src} = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ba(IDX_SECOND_CONTROL), 32'h0);
        rd(ba(IDX_GENERAL_BITS), 32'h0);
        rd(ba(IDX_CLKOUT_MASK), 32'h0);
        rd(32'h4C, 32'h0);
        bus(1'b1, ba(IDX_GENERAL_BITS), 32'hFF);
        rd(ba(IDX_GENERAL_BITS), 32'h7F);
        bus(1'b1, ba(IDX_CLKOUT_MASK), 32'hFF);
        rd(ba(IDX_CLKOUT_MASK), 32'h0F);
        bus(1'b1, ba(IDX_SECOND_CONTROL), 32'h02);
        repeat (2) @(posedge hclk);
        check({31'h0, h12}, 32'h1);
        // locked writes are dropped, reads still work
        bus(1'b1, ba(IDX_AUX_CONTROL), 32'h01);
        bus(1'b1, ba(IDX_GENERAL_BITS), 32'h55);
        rd(ba(IDX_GENERAL_BITS), 32'h7F);
        bus(1'b1, ba(IDX_AUX_CONTROL), 32'h00);
        bus(1'b1, ba(IDX_GENERAL_BITS), 32'h2A);
        rd(ba(IDX_GENERAL_BITS), 32'h2A);
        t_clkout(8'h04, 3'h4, 1'b1);
        t_clkout(8'h02, 3'h2, 1'b1);
        t_clkout(8'h01, 3'h1, 1'b1);
        t_clkout(8'h01, 3'h6, 1'b0);
        t_clkout(8'h06, 3'h2, 1'b1);
        // event pin, then backup switchover, each cleared through status
        bus(1'b1, ba(IDX_SECOND_CONTROL), 32'h04);
        i_far.pulse_event();
        repeat (20) @(posedge hclk);
        check({31'h0, irq_n}, 32'h0);
        t_clkout(8'h08, 3'h0, 1'b1);
        bus(1'b1, ba(IDX_STATUS), 32'h01);
        repeat (3) @(posedge hclk);
        check({31'h0, irq_n}, 32'h1);
        bus(1'b1, ba(IDX_AUX_CONTROL), 32'h06);
        bsw <= 1'b1;
        @(posedge hclk);
        bsw <= 1'b0;
        repeat (4) @(posedge hclk);
        check({31'h0, irq_n}, 32'h0);
        bus(1'b1, ba(IDX_STATUS), 32'h01);
        // sync reset clears itself and the slow stages; start just after the 64 hz clock rises
        for (int i = 0; i < 6000 && tclk === 1'b1; i++) @(posedge hclk);
        for (int i = 0; i < 6000 && tclk !== 1'b1; i++) @(posedge hclk);
        check({31'h0, tclk}, 32'h1);
        bus(1'b1, ba(IDX_SECOND_CONTROL), 32'h01);
        rd(ba(IDX_SECOND_CONTROL), 32'h0);
        check({31'h0, pend}, 32'h0);
        check({31'h0, tclk}, 32'h0);
        check({31'h0, uclk}, 32'h0);
        bus(1'b0, ba(IDX_PRESCALER), 32'h0);
        check(r & 32'h7FFC, 32'h0);
        report_and_stop();
    end
endmodule : rtc_control_and_clkout_mask_tb
